// ===== logic/lane_err_pkg.sv
package lane_err_pkg;

	localparam int LANES = 8;
	localparam int ERR_TYPES = 3;
	localparam int ADR_W = 13;
	localparam int IDX_W = 11;
	localparam int REG_W = 8;

	// Error type index; the same order is used by every 3-bit field.
	localparam int TYPE_CTRL_CHAR = 0;
	localparam int TYPE_NOT_IN_TABLE = 1;
	localparam int TYPE_DISPARITY = 2;

	// Word indices; the byte address is four times the index.
	localparam logic [IDX_W-1:0] IDX_SYNC_DUR = 11'h312;
	localparam logic [IDX_W-1:0] IDX_THRESHOLD = 11'h47C;
	localparam logic [IDX_W-1:0] IDX_MASK = 11'h47D;
	localparam logic [IDX_W-1:0] IDX_LANE0 = 11'h480;
	localparam logic [IDX_W-1:0] IDX_LANE7 = 11'h487;
	localparam logic [IDX_W-1:0] IDX_IRQ_EN = 11'h4B8;
	localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 11'h4BA;
	localparam logic [IDX_W-1:0] IDX_IRQ_CLEAR = 11'h4C0;
	localparam logic [IDX_W-1:0] IDX_LINK_STATE = 11'h4C1;

	// Field positions.
	localparam int DUR_LSB = 4;
	localparam int LC_MON_LSB = 3;
	localparam int LC_RST_LSB = 0;
	localparam int IRQ_ERR_LSB = 5;

	// Reset values.
	localparam logic [7:0] RST_THRESHOLD = 8'hFF;
	localparam logic [7:0] RST_MASK = 8'h00;
	localparam logic [7:0] RST_LANE_CTRL = 8'h3F;
	localparam logic [7:0] RST_IRQ_EN = 8'h00;
	localparam logic [3:0] RST_DUR = 4'h0;

	// Timing, in frame clock cycles, frames or octets, and the auto reinit error count.
	localparam int ERR_PULSE_FRAMES = 2;
	localparam int RESYNC_MIN_FRAMES = 5;
	localparam int RESYNC_MIN_OCTETS = 9;
	localparam int AUTO_REINIT_COUNT = 4;

	typedef logic [LANES-1:0] lane_vec_t;

	typedef struct packed {
		lane_vec_t disparity;
		lane_vec_t not_in_table;
		lane_vec_t ctrl_char;
	} lane_err_t;

	typedef enum {
		LINK_UP,
		LINK_REPORT,
		LINK_RESYNC
	} link_state_t;

endpackage : lane_err_pkg

// ===== logic/lane_error_resync_monitor.sv
// Decided for this implementation: the Wishbone register port.
`timescale 1ns/1ps

// Functional notes
// RQ1: Error report pulse holds sync request low for two frame clock cycles.
// RQ2: Pulse duration setting sits in bits 7:4 of its register, default 0.
// RQ3: Threshold events reach interrupt status only when enabled in bits 7:5.
// RQ4: Interrupt status bits 7:5 show the three error count events.
// RQ5: Four disparity or four not-in-table errors on a lane force reinit.
// RQ6: Reinit holds sync request low at least five frames plus nine octets.
// RQ7: Lane control bits 5:3 enable monitoring per type; all set after reset.
// RQ8: Lane control bits 2:0 hold counters in reset until software clears.
// RQ9: One shared threshold register serves all lanes and error types.
// RQ10: Masked error type reaching threshold on any lane drops sync request.
// RQ11: Every reinit clears all per-lane error counters.
// RQ12: Reinit leaves pending interrupt status untouched; software clears it.
// RQ13: Mask bit 2 disparity, bit 1 not-in-table, bit 0 control char.
// RQ14: Software selects errors, releases counters, sets mask, then threshold.
// RQ15: Each lane has three saturating counters, one per error type.
module lane_error_resync_monitor #(
	parameter int OCTETS_PER_FRAME = 1,
	parameter int CNT_W = 8
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [lane_err_pkg::ADR_W-1:0] adr_i,
	input wire logic [31:0] dat_i,
	input wire logic [3:0] sel_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	input wire lane_err_pkg::lane_err_t lane_errors,
	output logic sync_request_out_n,
	output logic irq
);

	localparam int LANES = lane_err_pkg::LANES;
	localparam int TYPES = lane_err_pkg::ERR_TYPES;
	// Five frames plus nine octets; the octets round up to whole frames since
	// the hold is counted in frame clock cycles.
	localparam int RESYNC_CYCLES = lane_err_pkg::RESYNC_MIN_FRAMES +
		(lane_err_pkg::RESYNC_MIN_OCTETS + OCTETS_PER_FRAME - 1) /
		OCTETS_PER_FRAME;
	localparam logic [7:0] RESYNC_LAST = 8'(RESYNC_CYCLES - 1);
	localparam logic [7:0] PULSE_LAST =
		8'(lane_err_pkg::ERR_PULSE_FRAMES - 1);
	localparam logic [2:0] AUTO_LIMIT =
		3'(lane_err_pkg::AUTO_REINIT_COUNT);

	// Register storage.
	logic [7:0] threshold_q;
	logic [7:0] mask_q;
	logic [7:0] lane_ctrl_q [LANES];
	logic [7:0] irq_en_q;
	logic [2:0] irq_stat_q;
	logic [2:0] irq_stat_d;
	logic [3:0] sync_dur_q;

	// Bus slave.
	logic ack_q;
	logic [31:0] rd_data_q;
	logic [31:0] rd_data_d;
	logic [lane_err_pkg::IDX_W-1:0] idx;
	logic req;
	logic wr_fire;
	logic wr_byte;
	logic [7:0] wr_val;
	logic [2:0] lane_sel;
	logic hit_lane;

	// Error supervision.
	logic [CNT_W-1:0] cnt_q [LANES][TYPES];
	logic [2:0] auto_q [LANES][2];
	logic [TYPES-1:0] err_now [LANES];
	logic [TYPES-1:0] thr_hit;
	logic auto_hit;
	logic reinit_req;
	logic any_err;
	logic clear_counts;

	lane_err_pkg::link_state_t state_q;
	lane_err_pkg::link_state_t state_d;
	logic [7:0] hold_q;
	logic [7:0] hold_d;
	logic sync_n_q;
	logic irq_q;

	// A threshold of zero would fire on an idle counter, so it disarms.
	function automatic logic reached(
		input logic [CNT_W-1:0] count,
		input logic [7:0] limit
	);
		return (limit != 8'h00) && (count >= CNT_W'(limit));
	endfunction : reached

	function automatic logic [CNT_W-1:0] sat_inc(
		input logic [CNT_W-1:0] count
	);
		return (&count) ? count : count + CNT_W'(1);
	endfunction : sat_inc

	// Lane control decode, shared by the counters and the report logic.
	function automatic logic monitored(
		input logic [7:0] ctrl,
		input int t
	);
		return ctrl[lane_err_pkg::LC_MON_LSB + t];
	endfunction : monitored

	function automatic logic held_in_reset(
		input logic [7:0] ctrl,
		input int t
	);
		return ctrl[lane_err_pkg::LC_RST_LSB + t];
	endfunction : held_in_reset

	// The automatic reinit counters stop at their limit instead of wrapping.
	function automatic logic [2:0] auto_step(
		input logic [2:0] count,
		input logic hit
	);
		return (hit && count != AUTO_LIMIT) ? count + 3'h1 : count;
	endfunction : auto_step

	assign dat_o = rd_data_q;
	assign ack_o = ack_q;
	assign sync_request_out_n = sync_n_q;
	assign irq = irq_q;

	// Regroup the error carrier by lane so the loops can index by type.
	always_comb begin
		for (int l = 0; l < LANES; l++) begin
			err_now[l][lane_err_pkg::TYPE_CTRL_CHAR] = lane_errors.ctrl_char[l];
			err_now[l][lane_err_pkg::TYPE_NOT_IN_TABLE] =
				lane_errors.not_in_table[l];
			err_now[l][lane_err_pkg::TYPE_DISPARITY] = lane_errors.disparity[l];
		end
	end

	// Address decode.
	assign idx = adr_i[lane_err_pkg::ADR_W-1:2];
	assign req = cyc_i && stb_i;
	assign wr_fire = req && we_i && ack_q;
	assign wr_byte = wr_fire && sel_i[0];
	assign wr_val = dat_i[7:0];
	assign hit_lane = (idx >= lane_err_pkg::IDX_LANE0) &&
		(idx <= lane_err_pkg::IDX_LANE7);
	assign lane_sel = idx[2:0];

	always_comb begin
		rd_data_d = 32'h0000_0000;
		if (idx == lane_err_pkg::IDX_SYNC_DUR) begin
			rd_data_d[lane_err_pkg::DUR_LSB +: 4] = sync_dur_q; // RQ2
		end else if (idx == lane_err_pkg::IDX_THRESHOLD) begin
			rd_data_d[7:0] = threshold_q;
		end else if (idx == lane_err_pkg::IDX_MASK) begin
			rd_data_d[7:0] = mask_q;
		end else if (hit_lane) begin
			rd_data_d[7:0] = lane_ctrl_q[lane_sel];
		end else if (idx == lane_err_pkg::IDX_IRQ_EN) begin
			rd_data_d[7:0] = irq_en_q;
		end else if (idx == lane_err_pkg::IDX_IRQ_STATUS) begin
			rd_data_d[lane_err_pkg::IRQ_ERR_LSB +: 3] = irq_stat_q; // RQ4
		end else if (idx == lane_err_pkg::IDX_LINK_STATE) begin
			rd_data_d[0] = (state_q == lane_err_pkg::LINK_RESYNC);
			rd_data_d[1] = (state_q == lane_err_pkg::LINK_REPORT);
			rd_data_d[4:2] = thr_hit;
		end
	end

	// One wait state: ack rises the cycle after the request is seen, and
	// the write lands on the edge at which the master samples ack.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ack_q <= 1'b0;
			rd_data_q <= 32'h0000_0000;
		end else if (clk_en) begin
			ack_q <= req && !ack_q;
			if (req && !ack_q) begin
				rd_data_q <= rd_data_d;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			sync_dur_q <= lane_err_pkg::RST_DUR;
			threshold_q <= lane_err_pkg::RST_THRESHOLD;
			mask_q <= lane_err_pkg::RST_MASK;
			irq_en_q <= lane_err_pkg::RST_IRQ_EN;
		end else if (clk_en && wr_byte) begin
			if (idx == lane_err_pkg::IDX_SYNC_DUR) begin
				sync_dur_q <= wr_val[lane_err_pkg::DUR_LSB +: 4]; // RQ2
			end else if (idx == lane_err_pkg::IDX_THRESHOLD) begin
				threshold_q <= wr_val; // RQ9
			end else if (idx == lane_err_pkg::IDX_MASK) begin
				mask_q <= wr_val; // RQ13
			end else if (idx == lane_err_pkg::IDX_IRQ_EN) begin
				irq_en_q <= wr_val; // RQ3
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			for (int l = 0; l < LANES; l++) begin
				lane_ctrl_q[l] <= lane_err_pkg::RST_LANE_CTRL; // RQ7
			end
		end else if (clk_en && wr_byte && hit_lane) begin
			lane_ctrl_q[lane_sel] <= wr_val;
		end
	end

	// Counters reset whenever a reinit starts and stay clear while the
	// link is down, so stale counts cannot retrigger on recovery.
	assign clear_counts = reinit_req ||
		(state_q == lane_err_pkg::LINK_RESYNC);

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			for (int l = 0; l < LANES; l++) begin
				for (int t = 0; t < TYPES; t++) begin
					cnt_q[l][t] <= '0;
				end
			end
		end else if (clk_en) begin
			for (int l = 0; l < LANES; l++) begin
				for (int t = 0; t < TYPES; t++) begin
					if (clear_counts) begin
						cnt_q[l][t] <= '0; // RQ11
					end else if (held_in_reset(lane_ctrl_q[l], t)) begin
						cnt_q[l][t] <= '0; // RQ8
					end else if (err_now[l][t] &&
						monitored(lane_ctrl_q[l], t)) begin
						cnt_q[l][t] <= sat_inc(cnt_q[l][t]); // RQ15
					end
				end
			end
		end
	end

	// The automatic reinit counts raw disparity and not-in-table errors,
	// independent of monitor enables, counter resets and threshold.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			for (int l = 0; l < LANES; l++) begin
				auto_q[l][0] <= 3'h0;
				auto_q[l][1] <= 3'h0;
			end
		end else if (clk_en) begin
			for (int l = 0; l < LANES; l++) begin
				if (clear_counts) begin
					auto_q[l][0] <= 3'h0;
					auto_q[l][1] <= 3'h0;
				end else begin
					auto_q[l][0] <= auto_step(auto_q[l][0],
						lane_errors.not_in_table[l]); // RQ5
					auto_q[l][1] <= auto_step(auto_q[l][1],
						lane_errors.disparity[l]); // RQ5
				end
			end
		end
	end

	// Threshold hits are levels: they stay up while any counter of a type
	// sits at or above the shared threshold.
	always_comb begin
		thr_hit = '0;
		for (int l = 0; l < LANES; l++) begin
			for (int t = 0; t < TYPES; t++) begin
				if (reached(cnt_q[l][t], threshold_q)) begin
					thr_hit[t] = 1'b1; // RQ9
				end
			end
		end
	end

	always_comb begin
		any_err = 1'b0;
		for (int l = 0; l < LANES; l++) begin
			for (int t = 0; t < TYPES; t++) begin
				if (err_now[l][t] && monitored(lane_ctrl_q[l], t)) begin
					any_err = 1'b1; // RQ7
				end
			end
		end
	end

	always_comb begin
		auto_hit = 1'b0;
		for (int l = 0; l < LANES; l++) begin
			if (auto_q[l][0] == AUTO_LIMIT || auto_q[l][1] == AUTO_LIMIT) begin
				auto_hit = 1'b1; // RQ5
			end
		end
	end

	// Unmasked threshold hits still reach interrupt status; only resync is masked.
	assign reinit_req = auto_hit || |(thr_hit & mask_q[2:0]); // RQ10

	// Link supervision: a reinit overrides an error report pulse.
	always_comb begin
		state_d = state_q;
		hold_d = hold_q;
		case (state_q)
			lane_err_pkg::LINK_UP: begin
				if (reinit_req) begin
					state_d = lane_err_pkg::LINK_RESYNC;
					hold_d = RESYNC_LAST; // RQ6
				end else if (any_err) begin
					state_d = lane_err_pkg::LINK_REPORT;
					hold_d = PULSE_LAST; // RQ1
				end
			end
			lane_err_pkg::LINK_REPORT: begin
				if (reinit_req) begin
					state_d = lane_err_pkg::LINK_RESYNC;
					hold_d = RESYNC_LAST; // RQ6
				end else if (hold_q == 8'h00) begin
					state_d = lane_err_pkg::LINK_UP;
				end else begin
					hold_d = hold_q - 8'h01;
				end
			end
			lane_err_pkg::LINK_RESYNC: begin
				if (hold_q == 8'h00) begin
					state_d = lane_err_pkg::LINK_UP;
				end else begin
					hold_d = hold_q - 8'h01;
				end
			end
			default: begin
				state_d = lane_err_pkg::LINK_UP;
				hold_d = 8'h00;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state_q <= lane_err_pkg::LINK_UP;
			hold_q <= 8'h00;
			sync_n_q <= 1'b1;
		end else if (clk_en) begin
			state_q <= state_d;
			hold_q <= hold_d;
			sync_n_q <= (state_d == lane_err_pkg::LINK_UP); // RQ10
		end
	end

	// Set wins over a clear in the same cycle; reinit never clears status.
	always_comb begin
		irq_stat_d = irq_stat_q;
		if (wr_byte && idx == lane_err_pkg::IDX_IRQ_CLEAR) begin
			irq_stat_d = irq_stat_q &
				~wr_val[lane_err_pkg::IRQ_ERR_LSB +: 3]; // RQ12
		end
		irq_stat_d = irq_stat_d |
			(thr_hit & irq_en_q[lane_err_pkg::IRQ_ERR_LSB +: 3]); // RQ3
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			irq_stat_q <= 3'h0;
			irq_q <= 1'b0;
		end else if (clk_en) begin
			irq_stat_q <= irq_stat_d; // RQ4
			irq_q <= |(irq_stat_d &
				irq_en_q[lane_err_pkg::IRQ_ERR_LSB +: 3]);
		end
	end

endmodule : lane_error_resync_monitor

// ===== testbench/lane_err_chk_sva.sv
`timescale 1ns/1ps

module lane_err_chk #(
	parameter int OCTETS_PER_FRAME = 1,
	parameter int CNT_W = 8
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [lane_err_pkg::ADR_W-1:0] adr_i,
	input wire logic [31:0] dat_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_o,
	input wire logic ack_o,
	input wire lane_err_pkg::lane_err_t lane_errors,
	input wire logic sync_request_out_n,
	input wire logic irq
);
	localparam int HOLD = lane_err_pkg::RESYNC_MIN_FRAMES +
		(lane_err_pkg::RESYNC_MIN_OCTETS + OCTETS_PER_FRAME - 1) /
		OCTETS_PER_FRAME;
	logic [4:0] low_q;

	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);

	// Length of the current sync request, saturating so long holds stay legal.
	always_ff @(posedge ref_clk) begin
		if (rst || sync_request_out_n) begin
			low_q <= 5'h00;
		end else if (low_q != 5'h1F) begin
			low_q <= low_q + 5'h01;
		end
	end

	AST_ACK_ONE: assert property (ack_o |=> !ack_o)
		else $error("ack held longer than one cycle");
	AST_ACK_ANSWER: assert property ((cyc_i && stb_i && !ack_o) |=> ack_o)
		else $error("bus request not answered");
	AST_ACK_CAUSE: assert property ($rose(ack_o) |-> $past(cyc_i && stb_i))
		else $error("ack without request");
	AST_DAT_HIGH_ZERO: assert property (
		ack_o |-> dat_o[31:8] == 24'h000000)
		else $error("read data upper bits set");
	AST_SYNC_MIN: assert property (
		$fell(sync_request_out_n) |=> !sync_request_out_n)
		else $error("sync request shorter than two cycles");
	AST_SYNC_LEN: assert property ($rose(sync_request_out_n) |->
		(low_q == 5'h02 || low_q >= 5'(HOLD)))
		else $error("sync request of wrong length");
	AST_SYNC_CAUSE: assert property (
		$fell(sync_request_out_n) |-> $past(|lane_errors))
		else $error("sync request without error");
	AST_IRQ_HOLD: assert property ($fell(irq) |->
		($past(ack_o && we_i) || $past(ack_o && we_i, 2)))
		else $error("irq dropped without a write");
endmodule : lane_err_chk

bind lane_error_resync_monitor lane_err_chk #(
	.OCTETS_PER_FRAME(OCTETS_PER_FRAME), .CNT_W(CNT_W)
) chk (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .cyc_i(cyc_i),
	.stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i),
	.dat_o(dat_o), .ack_o(ack_o), .lane_errors(lane_errors),
	.sync_request_out_n(sync_request_out_n), .irq(irq));

// ===== testbench/lane_error_resync_monitor_tb_top.sv
`timescale 1ns/1ps

module lane_error_resync_monitor_tb_top;
	localparam logic [10:0] THR = lane_err_pkg::IDX_THRESHOLD;
	localparam logic [10:0] MSK = lane_err_pkg::IDX_MASK;
	localparam logic [10:0] LN0 = lane_err_pkg::IDX_LANE0;
	localparam logic [10:0] IEN = lane_err_pkg::IDX_IRQ_EN;
	localparam logic [10:0] IST = lane_err_pkg::IDX_IRQ_STATUS;
	logic ref_clk = 1'b0;
	logic rst, clk_en, cyc_i, stb_i, we_i, ack_o, sync_request_out_n, irq;
	logic [12:0] adr_i;
	logic [31:0] dat_i, dat_o;
	logic [3:0] sel_i;
	lane_err_pkg::lane_err_t lane_errors;
	int miscompares = 0;
	int total_checks = 0;
	int run_len = 0;
	int last_run = 0;
	int falls = 0;
	int n0;

	lane_error_resync_monitor DUT (.ref_clk(ref_clk), .rst(rst),
		.clk_en(clk_en), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
		.adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i), .dat_o(dat_o),
		.ack_o(ack_o), .lane_errors(lane_errors),
		.sync_request_out_n(sync_request_out_n), .irq(irq));
	lane_tx_model tx (.ref_clk(ref_clk), .lane_errors(lane_errors));

	initial forever #25 ref_clk = ~ref_clk;

	// Length of the last finished sync request and the number of requests.
	always @(posedge ref_clk) begin
		if (sync_request_out_n === 1'b0) begin
			if (run_len == 0) falls++;
			run_len++;
		end else if (run_len != 0) begin
			last_run = run_len;
			run_len = 0;
		end
	end

	task automatic chk(input string nm, input logic [7:0] e,
		input logic [7:0] g);
		total_checks++;
		if (g !== e) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic wb(input logic w, input logic [10:0] idx, input logic [7:0] d,
		output logic [7:0] q);
		@(posedge ref_clk);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= {idx, 2'b00};
		dat_i <= {24'h000000, d};
		do begin
			@(posedge ref_clk);
		end while (ack_o !== 1'b1);
		q = dat_o[7:0];
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i <= 1'b0;
	endtask : wb

	task automatic rd(input logic [10:0] idx, input logic [7:0] e);
		logic [7:0] q;
		wb(1'b0, idx, 8'h00, q);
		chk($sformatf("reg %h", idx), e, q);
	endtask : rd

	task automatic wr(input logic [10:0] idx, input logic [7:0] d);
		logic [7:0] q;
		wb(1'b1, idx, d, q);
	endtask : wr

	task automatic complete_run();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : complete_run

	initial begin
		repeat (20000) @(posedge ref_clk);
		miscompares++;
		complete_run();
	end

	initial begin
		rst = 1'b1;
		clk_en = 1'b1;
		cyc_i = 1'b0;
		stb_i = 1'b0;
		we_i = 1'b0;
		adr_i = 13'h0000;
		dat_i = 32'h00000000;
		sel_i = 4'hF;
		repeat (20) @(posedge ref_clk);
		rst <= 1'b0;
		rd(THR, 8'hFF);
		rd(MSK, 8'h00);
		for (int i = 0; i < 8; i++) rd(LN0 + 11'(i), 8'h3F);
		rd(IEN, 8'h00);
		rd(lane_err_pkg::IDX_SYNC_DUR, 8'h00);
		rd(11'h100, 8'h00);
		wr(lane_err_pkg::IDX_SYNC_DUR, 8'h20);
		rd(lane_err_pkg::IDX_SYNC_DUR, 8'h20);
		wr(IST, 8'hE0);
		rd(IST, 8'h00);
		$display("register test done");
		wr(MSK, 8'h07);
		wr(THR, 8'h01);
		tx.send(0, 0, 1, 8);
		chk("held run", 8'h02, 8'(last_run));
		wr(LN0 + 11'h002, 8'h00);
		n0 = falls;
		tx.send(0, 2, 1, 8);
		chk("unmonitored", 8'(n0), 8'(falls));
		wr(MSK, 8'h00);
		wr(THR, 8'hFF);
		for (int t = 1; t < 3; t++) begin
			tx.send(t, 3, 3, 6);
			chk("three errors", 8'h02, 8'(last_run));
			tx.send(t, 3, 1, 20);
			chk("auto reinit", 8'h0F, 8'(last_run));
		end
		$display("auto reinit test done");
		for (int i = 0; i < 8; i++) wr(LN0 + 11'(i), 8'h38);
		wr(THR, 8'h01);
		tx.send(0, 0, 1, 8);
		chk("unmasked", 8'h02, 8'(last_run));
		rd(IST, 8'h00);
		chk("irq off", 8'h00, {7'h00, irq});
		wr(LN0, 8'h3F);
		wr(LN0, 8'h38);
		for (int t = 0; t < 3; t++) begin
			wr(MSK, 8'(8'h01 << t));
			wr(IEN, 8'(8'h20 << t));
			wr(THR, 8'h02);
			tx.send(t, 2 * t + 1, 2, 20);
			chk("threshold", 8'h0F, 8'(last_run));
			rd(IST, 8'(8'h20 << t));
			chk("irq on", 8'h01, {7'h00, irq});
			wr(lane_err_pkg::IDX_IRQ_CLEAR, 8'hE0);
			rd(IST, 8'h00);
			chk("irq clear", 8'h00, {7'h00, irq});
		end
		tx.send(2, 5, 1, 8);
		chk("counts cleared", 8'h02, 8'(last_run));
		wr(MSK, 8'h00);
		wr(THR, 8'hFF);
		tx.send(0, 6, 256, 4);
		rd(lane_err_pkg::IDX_LINK_STATE, 8'h04);
		$display("threshold test done");
		complete_run();
	end
endmodule : lane_error_resync_monitor_tb_top

// ===== testbench/lane_tx_model.sv
`timescale 1ns/1ps

module lane_tx_model (
	input wire logic ref_clk,
	output lane_err_pkg::lane_err_t lane_errors
);
	initial lane_errors = '0;

	// Sends n bad characters of type t on one lane, each one a single
	// cycle wide, so every error is a distinct character at the receiver.
	task automatic send(input int t, input int lane, input int n,
		input int gap);
		repeat (n) begin
			@(posedge ref_clk);
			lane_errors[t * lane_err_pkg::LANES + lane] <= 1'b1;
			@(posedge ref_clk);
			lane_errors <= '0;
			repeat (gap) @(posedge ref_clk);
		end
	endtask : send
endmodule : lane_tx_model
